/* File: hdl/acp_defs.svh */
// register map, field positions and reset values of the cell policer
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH
`define ACP_AW 7
`define ACP_REG_CTRL 7'h00
`define ACP_REG_STATUS 7'h04
`define ACP_REG_ENTRY 7'h08
`define ACP_REG_KEY 7'h0c
`define ACP_REG_CONF 7'h10
`define ACP_REG_XLAT 7'h14
`define ACP_REG_PINC 7'h18
`define ACP_REG_PLIM 7'h1c
`define ACP_REG_SINC 7'h20
`define ACP_REG_SLIM 7'h24
`define ACP_REG_CMD 7'h28
`define ACP_REG_SVC_VPI 7'h2c
`define ACP_REG_SVC_VCI 7'h30
`define ACP_REG_CNT_PASS 7'h34
`define ACP_REG_CNT_TAG 7'h38
`define ACP_REG_CNT_DROP 7'h3c
`define ACP_REG_CNT_MISS 7'h40
`define ACP_VPI_W 12
`define ACP_VCI_W 16
`define ACP_PORT_W 4
`define ACP_TIME_W 24
`define ACP_CTRL_EN 0
`define ACP_CTRL_RST 32'h0000_0001
`define ACP_CMD_GO 0
`define ACP_KEY_VCI_LSB 12
`define ACP_KEY_VPONLY 28
`define ACP_KEY_VALID 29
`define ACP_CONF_SET_LSB 4
`define ACP_CONF_CLP 8
`define ACP_CONF_PORT_LSB 16
`define ACP_RNG_HI_LSB 16
`define ACP_RNG_EMPTY 32'h0000_ffff
`define ACP_POL_VBR1 3'h1
`define ACP_POL_VBR2 3'h2
`define ACP_POL_VBR3 3'h3
`define ACP_POL_PCR 3'h4
`define ACP_POL_OFF 3'h5
`endif

/* File: hdl/acp_fifo.sv */
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module acp_fifo #(
	parameter int W = 64,
	parameter int D = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic rdy_r, rdy_nxt, vld_r, vld_nxt;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	////////////////////////////////////////////////////////////////////////
	// flags are registered so the ports come from flops
	always_comb begin
		push = in_valid_i && rdy_r;
		pop = vld_r && out_ready_i;
		wr_nxt = push ? bump(wr_r) : wr_r;
		rd_nxt = pop ? bump(rd_r) : rd_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		rdy_nxt = (cnt_nxt != (AW+1)'(D));
		vld_nxt = (cnt_nxt != '0);
	end

	// storage has no reset; only words pushed and not yet popped are ever read
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
		if (rst_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b1;
			vld_r <= 1'b0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
			vld_r <= vld_nxt;
		end
	end

	assign in_ready_o = rdy_r;
	assign out_valid_o = vld_r;
	assign out_data_o = mem_r[rd_r];
endmodule : acp_fifo

/* File: hdl/acp_gcra.sv */
// one leaky bucket: conformance test by theoretical arrival time
`timescale 1ns/1ps
module acp_gcra #(
	parameter int TW = 24
) (
	input wire logic [TW-1:0] now_i,
	input wire logic [TW-1:0] tat_i,
	input wire logic [TW-1:0] inc_i,
	input wire logic [TW-1:0] lim_i,
	output logic ok_o,
	output logic [TW-1:0] tat_o
);
	logic [TW-1:0] ahead;

	// wrap-safe: a tat in the past shows as a negative lead
	always_comb begin
		ahead = tat_i - now_i;
		if (ahead[TW-1]) begin
			ok_o = 1'b1;
			tat_o = now_i + inc_i;
		end else begin
			ok_o = (ahead <= lim_i);
			tat_o = tat_i + inc_i;
		end
	end
endmodule : acp_gcra

/* File: hdl/acp_pkg.sv */
// types shared by the cell policer modules
`include "acp_defs.svh"
package acp_pkg;
	typedef enum logic [2:0] {conn_cbr, conn_vbr, conn_abr, conn_ubr,
		conn_frame_interwork, conn_frame_interwork_flow_ctl} acp_conn_t;
	typedef enum logic {bus_idle, bus_ack} acp_bus_t;
	typedef struct packed {
		logic pcr_en;
		logic scr_en;
		logic scr_clp0;
		logic scr_tag;
	} acp_pol_t;
	typedef struct packed {
		logic valid;
		logic vp_only;
		logic [`ACP_VPI_W-1:0] vpi;
		logic [`ACP_VCI_W-1:0] vci;
		acp_conn_t ctype;
		logic [2:0] pol;
		logic clp_opt;
		logic [`ACP_PORT_W-1:0] port;
		logic [`ACP_VPI_W-1:0] xvpi;
		logic [`ACP_VCI_W-1:0] xvci;
		logic [`ACP_TIME_W-1:0] pinc;
		logic [`ACP_TIME_W-1:0] plim;
		logic [`ACP_TIME_W-1:0] sinc;
		logic [`ACP_TIME_W-1:0] slim;
	} acp_entry_t;
endpackage : acp_pkg

/* File: hdl/acp_policer.sv */
// cell lookup, translation and dual-bucket policer with avalon registers
//
// Notes on behaviour
// - entry with vpi and vci switches cells on the full pair
// - entry with vpi only takes every cell of that vpi, any vci
// - all vpi and vci values are legal keys except those inside the switched-circuit ranges
// - identifiers are local; vpi is rewritten from the matched entry, vci too except on a path entry
// - setup inside switched-circuit ranges is refused, entry kept
// - setting 1 polices all cells in both buckets, no tagging
// - setting 2 polices all in peak, clp0 in sustained, no tagging
// - setting 3 like 2 but sustained failures are tagged, not dropped
// - setting 4 polices all cells on peak only, sustained off
// - setting 5 turns both buckets off, cells pass untouched
// - unspecified rate, clp option clear: peak only, no tag
// - unspecified rate, clp option set: peak plus tagged clp0 bucket
// - available rate and frame interworking types behave as variable
// - tagging rewrites clp from 0 to 1
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module acp_policer
	import acp_pkg::*;
#(
	parameter int N_ENT = 16,
	parameter int DW = 32,
	parameter int FIFO_D = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [`ACP_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic cell_valid_i,
	output logic cell_ready_o,
	input wire logic [`ACP_VPI_W-1:0] cell_vpi_i,
	input wire logic [`ACP_VCI_W-1:0] cell_vci_i,
	input wire logic [2:0] cell_pti_i,
	input wire logic cell_clp_i,
	input wire logic [DW-1:0] cell_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [`ACP_VPI_W-1:0] out_vpi_o,
	output logic [`ACP_VCI_W-1:0] out_vci_o,
	output logic [2:0] out_pti_o,
	output logic out_clp_o,
	output logic [`ACP_PORT_W-1:0] out_port_o,
	output logic [DW-1:0] out_data_o
);
	localparam int IW = $clog2(N_ENT);
	localparam int TW = `ACP_TIME_W;
	localparam int FW = 3 + 1 + `ACP_VPI_W + `ACP_VCI_W + DW;

	acp_bus_t bus_r, bus_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt, rd_mux;
	logic [31:0] ctrl_r, ctrl_nxt, key_r, key_nxt, conf_r, conf_nxt;
	logic [31:0] xlat_r, xlat_nxt, svpi_r, svpi_nxt, svci_r, svci_nxt;
	logic [TW-1:0] pinc_r, pinc_nxt, plim_r, plim_nxt;
	logic [TW-1:0] sinc_r, sinc_nxt, slim_r, slim_nxt;
	logic [IW-1:0] entry_r, entry_nxt;
	logic refused_r, refused_nxt;
	logic [31:0] cpass_r, cpass_nxt, ctag_r, ctag_nxt;
	logic [31:0] cdrop_r, cdrop_nxt, cmiss_r, cmiss_nxt;
	logic wr_ack, commit, refuse;
	acp_entry_t stg;
	acp_entry_t tbl_r [N_ENT];
	acp_entry_t tbl_nxt [N_ENT];
	logic [TW-1:0] ptat_r [N_ENT];
	logic [TW-1:0] ptat_nxt [N_ENT];
	logic [TW-1:0] stat_r [N_ENT];
	logic [TW-1:0] stat_nxt [N_ENT];
	logic [TW-1:0] now_r, now_nxt;
	logic f_vld, f_rdy;
	logic [FW-1:0] f_data;
	logic [`ACP_VPI_W-1:0] c_vpi;
	logic [`ACP_VCI_W-1:0] c_vci;
	logic [2:0] c_pti;
	logic c_clp;
	logic [DW-1:0] c_data;
	logic hit, vp_hit;
	logic [IW-1:0] idx, vp_idx;
	acp_entry_t ent;
	acp_pol_t pol;
	logic p_ok, s_ok, pcr_ok, scr_use, scr_fail, pass, tag, proc;
	logic [TW-1:0] p_tat, s_tat;
	logic ov_r, ov_nxt, oclp_r, oclp_nxt;
	logic [`ACP_VPI_W-1:0] ovpi_r, ovpi_nxt;
	logic [`ACP_VCI_W-1:0] ovci_r, ovci_nxt;
	logic [2:0] opti_r, opti_nxt;
	logic [`ACP_PORT_W-1:0] oport_r, oport_nxt;
	logic [DW-1:0] odata_r, odata_nxt;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		return m;
	endfunction : merge

	// range word holds lo in the low half, hi in the high half
	function automatic logic in_rng(input logic [15:0] v,
		input logic [31:0] rng);
		return v >= rng[15:0] && v <= rng[`ACP_RNG_HI_LSB +: 16];
	endfunction : in_rng

	// bucket usage per connection type and policing setting
	function automatic acp_pol_t pol_decode(input acp_entry_t e);
		acp_pol_t p;
		p = '0;
		if (e.ctype == conn_ubr) begin
			p.pcr_en = 1'b1;
			p.scr_en = e.clp_opt;
			p.scr_clp0 = 1'b1;
			p.scr_tag = 1'b1;
		end else if (e.ctype == conn_cbr) begin
			p.pcr_en = (e.pol != `ACP_POL_OFF);
		end else begin
			// available rate and interworking share this path
			case (e.pol)
				`ACP_POL_VBR1: p = '{1'b1, 1'b1, 1'b0, 1'b0};
				`ACP_POL_VBR2: p = '{1'b1, 1'b1, 1'b1, 1'b0};
				`ACP_POL_VBR3: p = '{1'b1, 1'b1, 1'b1, 1'b1};
				`ACP_POL_PCR: p = '{1'b1, 1'b0, 1'b0, 1'b0};
				default: p = '0; // off and unused codes
			endcase
		end
		return p;
	endfunction : pol_decode

	////////////////////////////////////////////////////////////////////////
	// avalon slave: request seen, then one cycle with waitrequest low

	always_comb begin
		case (avs_address_i)
			`ACP_REG_CTRL: rd_mux = ctrl_r;
			`ACP_REG_STATUS: rd_mux = {31'h0, refused_r};
			`ACP_REG_ENTRY: rd_mux = 32'(entry_r);
			`ACP_REG_KEY: rd_mux = key_r;
			`ACP_REG_CONF: rd_mux = conf_r;
			`ACP_REG_XLAT: rd_mux = xlat_r;
			`ACP_REG_PINC: rd_mux = 32'(pinc_r);
			`ACP_REG_PLIM: rd_mux = 32'(plim_r);
			`ACP_REG_SINC: rd_mux = 32'(sinc_r);
			`ACP_REG_SLIM: rd_mux = 32'(slim_r);
			`ACP_REG_SVC_VPI: rd_mux = svpi_r;
			`ACP_REG_SVC_VCI: rd_mux = svci_r;
			`ACP_REG_CNT_PASS: rd_mux = cpass_r;
			`ACP_REG_CNT_TAG: rd_mux = ctag_r;
			`ACP_REG_CNT_DROP: rd_mux = cdrop_r;
			`ACP_REG_CNT_MISS: rd_mux = cmiss_r;
			default: rd_mux = 32'h0; // unmapped and command read zero
		endcase
	end

	// writes land on the edge where the master sees waitrequest low
	always_comb begin
		bus_nxt = bus_r;
		wait_nxt = 1'b1;
		rdata_nxt = rdata_r;
		wr_ack = (bus_r == bus_ack) && avs_write_i;
		{ctrl_nxt, key_nxt, conf_nxt, xlat_nxt} =
			{ctrl_r, key_r, conf_r, xlat_r};
		{svpi_nxt, svci_nxt, entry_nxt} = {svpi_r, svci_r, entry_r};
		{pinc_nxt, plim_nxt, sinc_nxt, slim_nxt} =
			{pinc_r, plim_r, sinc_r, slim_r};
		unique case (bus_r)
			bus_idle: begin
				if (avs_read_i || avs_write_i) begin
					bus_nxt = bus_ack;
					wait_nxt = 1'b0;
					rdata_nxt = avs_read_i ? rd_mux : rdata_r;
				end
			end
			bus_ack: begin
				bus_nxt = bus_idle;
			end
		endcase
		if (wr_ack) begin
			case (avs_address_i)
				`ACP_REG_CTRL: ctrl_nxt =
					merge(ctrl_r, avs_writedata_i, avs_byteenable_i);
				`ACP_REG_ENTRY: entry_nxt = IW'(merge(32'(entry_r),
					avs_writedata_i, avs_byteenable_i));
				`ACP_REG_KEY: key_nxt =
					merge(key_r, avs_writedata_i, avs_byteenable_i);
				`ACP_REG_CONF: conf_nxt =
					merge(conf_r, avs_writedata_i, avs_byteenable_i);
				`ACP_REG_XLAT: xlat_nxt =
					merge(xlat_r, avs_writedata_i, avs_byteenable_i);
				`ACP_REG_PINC: pinc_nxt = TW'(merge(32'(pinc_r),
					avs_writedata_i, avs_byteenable_i));
				`ACP_REG_PLIM: plim_nxt = TW'(merge(32'(plim_r),
					avs_writedata_i, avs_byteenable_i));
				`ACP_REG_SINC: sinc_nxt = TW'(merge(32'(sinc_r),
					avs_writedata_i, avs_byteenable_i));
				`ACP_REG_SLIM: slim_nxt = TW'(merge(32'(slim_r),
					avs_writedata_i, avs_byteenable_i));
				`ACP_REG_SVC_VPI: svpi_nxt =
					merge(svpi_r, avs_writedata_i, avs_byteenable_i);
				`ACP_REG_SVC_VCI: svci_nxt =
					merge(svci_r, avs_writedata_i, avs_byteenable_i);
				default: ; // counters, status, unmapped: ignored
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bus_r <= bus_idle;
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
			ctrl_r <= `ACP_CTRL_RST;
			{key_r, conf_r, xlat_r} <= '0;
			svpi_r <= `ACP_RNG_EMPTY;
			svci_r <= `ACP_RNG_EMPTY;
			entry_r <= '0;
			{pinc_r, plim_r, sinc_r, slim_r} <= '0;
		end else begin
			bus_r <= bus_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			{ctrl_r, key_r, conf_r, xlat_r} <=
				{ctrl_nxt, key_nxt, conf_nxt, xlat_nxt};
			{svpi_r, svci_r, entry_r} <= {svpi_nxt, svci_nxt, entry_nxt};
			{pinc_r, plim_r, sinc_r, slim_r} <=
				{pinc_nxt, plim_nxt, sinc_nxt, slim_nxt};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// staged entry and the refusal check for switched-circuit ranges

	always_comb begin
		stg.valid = key_r[`ACP_KEY_VALID];
		stg.vp_only = key_r[`ACP_KEY_VPONLY];
		stg.vpi = key_r[`ACP_VPI_W-1:0];
		stg.vci = key_r[`ACP_KEY_VCI_LSB +: `ACP_VCI_W];
		stg.ctype = acp_conn_t'(conf_r[2:0]);
		stg.pol = conf_r[`ACP_CONF_SET_LSB +: 3];
		stg.clp_opt = conf_r[`ACP_CONF_CLP];
		stg.port = conf_r[`ACP_CONF_PORT_LSB +: `ACP_PORT_W];
		stg.xvpi = xlat_r[`ACP_VPI_W-1:0];
		stg.xvci = xlat_r[`ACP_KEY_VCI_LSB +: `ACP_VCI_W];
		{stg.pinc, stg.plim, stg.sinc, stg.slim} =
			{pinc_r, plim_r, sinc_r, slim_r};
		commit = wr_ack && (avs_address_i == `ACP_REG_CMD) &&
			avs_byteenable_i[0] && avs_writedata_i[`ACP_CMD_GO];
		// removing an entry is never refused
		refuse = stg.valid && (in_rng(16'(stg.vpi), svpi_r) ||
			(!stg.vp_only && in_rng(stg.vci, svci_r)));
	end

	////////////////////////////////////////////////////////////////////////
	// input fifo and lookup across the whole table

	acp_fifo #(
		.W(FW),
		.D(FIFO_D)
	) u_fifo (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_valid_i(cell_valid_i),
		.in_data_i({cell_pti_i, cell_clp_i, cell_vpi_i, cell_vci_i,
			cell_data_i}),
		.in_ready_o(cell_ready_o),
		.out_valid_o(f_vld),
		.out_data_o(f_data),
		.out_ready_i(f_rdy)
	);

	// a channel entry beats a path entry with the same vpi
	always_comb begin
		{c_pti, c_clp, c_vpi, c_vci, c_data} = f_data;
		hit = 1'b0;
		vp_hit = 1'b0;
		idx = '0;
		vp_idx = '0;
		for (int i = N_ENT - 1; i >= 0; i--) begin
			if (tbl_r[i].valid && tbl_r[i].vpi == c_vpi) begin
				if (tbl_r[i].vp_only) begin
					vp_hit = 1'b1;
					vp_idx = IW'(i);
				end else if (tbl_r[i].vci == c_vci) begin
					hit = 1'b1;
					idx = IW'(i);
				end
			end
		end
		if (!hit) begin
			hit = vp_hit;
			idx = vp_idx;
		end
		ent = tbl_r[idx];
		pol = pol_decode(ent);
	end

	acp_gcra #(.TW(TW)) u_pcr (
		.now_i(now_r),
		.tat_i(ptat_r[idx]),
		.inc_i(ent.pinc),
		.lim_i(ent.plim),
		.ok_o(p_ok),
		.tat_o(p_tat)
	);

	acp_gcra #(.TW(TW)) u_scr (
		.now_i(now_r),
		.tat_i(stat_r[idx]),
		.inc_i(ent.sinc),
		.lim_i(ent.slim),
		.ok_o(s_ok),
		.tat_o(s_tat)
	);

	////////////////////////////////////////////////////////////////////////
	// policing decision, table and bucket state, counters

	always_comb begin
		pcr_ok = !pol.pcr_en || p_ok;
		scr_use = pol.scr_en && (!c_clp || !pol.scr_clp0);
		scr_fail = scr_use && !s_ok;
		pass = hit && pcr_ok && (!scr_fail || pol.scr_tag);
		tag = scr_fail && pol.scr_tag;
		// a table commit owns the cycle so tat writes never collide
		proc = f_vld && ctrl_r[`ACP_CTRL_EN] && !commit &&
			(!ov_r || out_ready_i);
		f_rdy = proc;
		now_nxt = now_r + 1'b1;
		tbl_nxt = tbl_r;
		ptat_nxt = ptat_r;
		stat_nxt = stat_r;
		refused_nxt = commit ? refuse : refused_r;
		if (commit && !refuse) begin
			tbl_nxt[entry_r] = stg;
			ptat_nxt[entry_r] = now_r; // fresh buckets start empty
			stat_nxt[entry_r] = now_r;
		end
		// misses and dropped cells leave the buckets alone
		if (proc && pass && pol.pcr_en) begin
			ptat_nxt[idx] = p_tat;
		end
		if (proc && pass && scr_use && !scr_fail) begin
			stat_nxt[idx] = s_tat;
		end
		cpass_nxt = cpass_r + 32'(proc && pass);
		ctag_nxt = ctag_r + 32'(proc && pass && tag);
		cdrop_nxt = cdrop_r + 32'(proc && hit && !pass);
		cmiss_nxt = cmiss_r + 32'(proc && !hit);
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			now_r <= '0;
			refused_r <= 1'b0;
			{cpass_r, ctag_r, cdrop_r, cmiss_r} <= '0;
			for (int i = 0; i < N_ENT; i++) begin
				tbl_r[i] <= '0;
				ptat_r[i] <= '0;
				stat_r[i] <= '0;
			end
		end else begin
			now_r <= now_nxt;
			refused_r <= refused_nxt;
			{cpass_r, ctag_r, cdrop_r, cmiss_r} <=
				{cpass_nxt, ctag_nxt, cdrop_nxt, cmiss_nxt};
			tbl_r <= tbl_nxt;
			ptat_r <= ptat_nxt;
			stat_r <= stat_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output stage: translated header, tagged clp, destination port

	always_comb begin
		ov_nxt = out_ready_i ? 1'b0 : ov_r;
		{ovpi_nxt, ovci_nxt, opti_nxt, oclp_nxt, oport_nxt, odata_nxt} =
			{ovpi_r, ovci_r, opti_r, oclp_r, oport_r, odata_r};
		if (proc && pass) begin
			ov_nxt = 1'b1;
			ovpi_nxt = ent.xvpi;
			// a path connection carries the vci through unchanged
			ovci_nxt = ent.vp_only ? c_vci : ent.xvci;
			opti_nxt = c_pti;
			oclp_nxt = c_clp | tag;
			oport_nxt = ent.port;
			odata_nxt = c_data;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ov_r <= 1'b0;
			{ovpi_r, ovci_r, opti_r, oclp_r, oport_r, odata_r} <= '0;
		end else begin
			ov_r <= ov_nxt;
			{ovpi_r, ovci_r, opti_r, oclp_r, oport_r, odata_r} <=
				{ovpi_nxt, ovci_nxt, opti_nxt, oclp_nxt, oport_nxt,
				odata_nxt};
		end
	end

	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign out_valid_o = ov_r;
	assign out_vpi_o = ovpi_r;
	assign out_vci_o = ovci_r;
	assign out_pti_o = opti_r;
	assign out_clp_o = oclp_r;
	assign out_port_o = oport_r;
	assign out_data_o = odata_r;
endmodule : acp_policer

/* File: tb/acp_cell_src.sv */
// cell source standing for the customer side of the link
`timescale 1ns/1ps
module acp_cell_src #(
	parameter int DW = 32
) (
	input logic clock_i,
	input logic rst_i,
	input logic slow_i,
	input logic ready_i,
	output logic valid_o,
	output logic [11:0] vpi_o,
	output logic [15:0] vci_o,
	output logic [2:0] pti_o,
	output logic clp_o,
	output logic [DW-1:0] data_o
);
	logic [DW+31:0] q[$];
	logic [DW+31:0] cur_r;
	assign {vpi_o, vci_o, pti_o, clp_o, data_o} = cur_r;
	////////////////////////////////////////////////////////////////////////
	// a cell is held until taken; idle lines toggle so stale headers differ
	always @(posedge clock_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			cur_r <= '0;
		end else if (!(valid_o && !ready_i)) begin
			if (q.size() > 0 && !(slow_i && $urandom_range(1, 0) == 0)) begin
				cur_r <= q.pop_front();
				valid_o <= 1'b1;
			end else begin
				cur_r <= ~cur_r;
				valid_o <= 1'b0;
			end
		end
	end
endmodule : acp_cell_src

/* File: tb/acp_policer_asserts.sv */
// port assertions of the cell policer and their bind
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_policer_asserts #(
	parameter int DW = 32
) (
	input logic clock_i,
	input logic rst_i,
	input logic [`ACP_AW-1:0] avs_address_i,
	input logic avs_read_i,
	input logic avs_write_i,
	input logic [31:0] avs_readdata_o,
	input logic avs_waitrequest_o,
	input logic cell_valid_i,
	input logic cell_ready_o,
	input logic out_valid_o,
	input logic out_ready_i,
	input logic [`ACP_VPI_W-1:0] out_vpi_o,
	input logic [`ACP_VCI_W-1:0] out_vci_o,
	input logic out_clp_o,
	input logic [`ACP_PORT_W-1:0] out_port_o,
	input logic [DW-1:0] out_data_o
);
	logic [15:0] n_in_r, n_out_r;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	// cells taken and delivered; an output may never outrun its input
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			n_in_r <= 16'h0000;
			n_out_r <= 16'h0000;
		end else begin
			n_in_r <= n_in_r + 16'(cell_valid_i && cell_ready_o);
			n_out_r <= n_out_r + 16'(out_valid_o && out_ready_i);
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	bus_answer_a: assert property (s_req |=> s_ans)
		else $error("bus answer not one cycle after request");
	idle_wait_a: assert property (!avs_read_i && !avs_write_i |=>
		avs_waitrequest_o) else $error("answer without request");
	rd_hold_a: assert property (!(avs_read_i && avs_waitrequest_o) |=>
		$stable(avs_readdata_o)) else $error("read data moved");
	rd_zero_a: assert property (avs_read_i && avs_waitrequest_o &&
		(avs_address_i == `ACP_REG_CMD || avs_address_i > `ACP_REG_CNT_MISS)
		|=> avs_readdata_o == 32'h0) else $error("read not zero");
	out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o
		&& $stable({out_vpi_o, out_vci_o, out_clp_o, out_port_o, out_data_o}))
		else $error("output cell not held");
	out_src_a: assert property (out_valid_o |-> n_in_r > n_out_r)
		else $error("cell out with none in");
	rdy_fall_a: assert property ($fell(cell_ready_o) |-> $past(cell_valid_i))
		else $error("ready fell without a taken cell");
	reset_state_a: assert property (disable iff (1'b0) rst_i |=>
		!out_valid_o && avs_waitrequest_o) else $error("bad reset state");
endmodule : acp_policer_asserts
bind acp_policer acp_policer_asserts #(.DW(DW)) chk_u (.clock_i, .rst_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
	.avs_waitrequest_o, .cell_valid_i, .cell_ready_o, .out_valid_o,
	.out_ready_i, .out_vpi_o, .out_vci_o, .out_clp_o, .out_port_o,
	.out_data_o);

/* File: tb/tb.sv */
// self-checking bench for the cell policer with a reference model
`timescale 1ns/1ps
`include "acp_defs.svh"
module tb;
	import acp_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [6:0] avs_address_i = 7'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o, cell_data_i, out_data_o, rd;
	logic avs_waitrequest_o, cell_valid_i, cell_ready_o, cell_clp_i;
	logic out_valid_o, out_clp_o, slow = 1'b0;
	logic out_ready_i = 1'b1;
	logic [11:0] cell_vpi_i, out_vpi_o;
	logic [15:0] cell_vci_i, out_vci_o;
	logic [2:0] cell_pti_i, out_pti_o;
	logic [3:0] out_port_o;
	logic [31:0] m[16][7];
	int tat[16][2];
	int err_count = 0, n_tests = 0, cyc = 0, n_miss = 0, rmode = 1;
	int vlo = 4095, vhi = 0;
	logic [67:0] eq[$];
	initial forever #50 clock_i = ~clock_i;
	acp_policer #(.N_ENT(16), .DW(32), .FIFO_D(8)) dut_u (.clock_i, .rst_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
		.cell_valid_i, .cell_ready_o, .cell_vpi_i, .cell_vci_i, .cell_pti_i,
		.cell_clp_i, .cell_data_i, .out_valid_o, .out_ready_i, .out_vpi_o,
		.out_vci_o, .out_pti_o, .out_clp_o, .out_port_o, .out_data_o);
	acp_cell_src src_u (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
		.ready_i(cell_ready_o), .valid_o(cell_valid_i), .vpi_o(cell_vpi_i),
		.vci_o(cell_vci_i), .pti_o(cell_pti_i), .clp_o(cell_clp_i),
		.data_o(cell_data_i));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [67:0] got, input logic [67:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input bit w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 40);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n == 40) chk(1, 0);
	endtask : bus
	// stage, commit and predict refusal
	task automatic ent(input int i, input logic [31:0] v[7]);
		bit bad;
		bus(1, `ACP_REG_ENTRY, i);
		for (int k = 0; k < 7; k++) bus(1, 7'(12 + 4 * k), v[k]);
		bus(1, `ACP_REG_CMD, 1);
		bad = v[0][29] && v[0][11:0] >= vlo && v[0][11:0] <= vhi;
		if (!bad) begin
			m[i] = v;
			tat[i] = '{cyc, cyc};
		end
		bus(0, `ACP_REG_STATUS, 0);
		chk(rd, bad);
	endtask : ent
	// buckets in use: peak, sustained, sustained clp0 only, tagging
	function automatic logic [3:0] mode(input logic [31:0] c);
		if (c[2:0] == 3) return c[8] ? 4'b1111 : 4'b1000;
		if (c[2:0] == 0) return c[6:4] == 5 ? 4'b0000 : 4'b1000;
		case (c[6:4])
			1: return 4'b1100;
			2: return 4'b1110;
			3: return 4'b1111;
			4: return 4'b1000;
			default: return 4'b0000;
		endcase
	endfunction : mode
	// channel beats path, lowest index first
	function automatic int find(input logic [11:0] p, input logic [15:0] v);
		int hc, hp;
		hc = -1;
		hp = -1;
		for (int k = 15; k >= 0; k--) begin
			if (m[k][0][29] && m[k][0][11:0] == p) begin
				if (!m[k][0][28] && m[k][0][27:12] == v) hc = k;
				if (m[k][0][28]) hp = k;
			end
		end
		return hc >= 0 ? hc : hp;
	endfunction : find
	// reference decision, queued if the cell leaves
	task automatic model(input logic [63:0] c);
		int i, now, l0, l1;
		logic [3:0] md;
		bit ok0, ok1, sus, clp;
		i = find(c[63:52], c[51:36]);
		if (i < 0) begin
			n_miss++;
			return;
		end
		md = mode(m[i][1]);
		now = cyc;
		clp = c[32];
		l0 = tat[i][0] - now;
		l1 = tat[i][1] - now;
		ok0 = !md[3] || l0 <= int'(m[i][4]);
		sus = md[2] && !(md[1] && clp);
		ok1 = !sus || l1 <= int'(m[i][6]);
		if (!ok0 || (!ok1 && !md[0])) return;
		if (md[3]) tat[i][0] = (l0 < 0 ? now : tat[i][0]) + int'(m[i][3]);
		if (sus && ok1) tat[i][1] = (l1 < 0 ? now : tat[i][1]) + int'(m[i][5]);
		clp = clp | !ok1;
		eq.push_back({m[i][1][19:16], m[i][2][11:0],
			m[i][0][28] ? c[51:36] : m[i][2][27:12], c[35:33], clp, c[31:0]});
	endtask : model
	task automatic send(input logic [11:0] p, input logic [15:0] v);
		src_u.q.push_back({p, v, 3'($urandom), 1'($urandom), $urandom});
	endtask : send
	task automatic drain();
		int n;
		n = 0;
		while ((src_u.q.size() || cell_valid_i || eq.size()) && n < 2000) begin
			@(posedge clock_i);
			n++;
		end
		if (n == 2000) chk(1, 0);
		repeat (12) @(posedge clock_i);
	endtask : drain
	////////////////////////////////////////////////////////////////////////
	// model every taken cell, compare every delivery; timeout
	always @(posedge clock_i) begin
		out_ready_i <= rmode == 2 ? 1'($urandom) : rmode[0];
		if (!rst_i) begin
			cyc++;
			if (cell_valid_i && cell_ready_o)
				model({cell_vpi_i, cell_vci_i, cell_pti_i, cell_clp_i, cell_data_i});
			if (out_valid_o && out_ready_i)
				chk({out_port_o, out_vpi_o, out_vci_o, out_pti_o, out_clp_o,
					out_data_o}, eq.size() ? eq.pop_front() : 68'bx);
			if (cyc > 40000) begin
				chk(1, 0);
				give_verdict();
			end
		end
	end
	initial begin
		logic [31:0] e[7];
		logic [6:0] ra[5] = '{`ACP_REG_CTRL, `ACP_REG_STATUS, `ACP_REG_SVC_VCI,
			`ACP_REG_CMD, 7'h44};
		logic [31:0] rv[5] = '{`ACP_CTRL_RST, 0, `ACP_RNG_EMPTY, 0, 0};
		void'($urandom(71));
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		// reset values; status read-only, unmapped and command read 0
		bus(1, `ACP_REG_STATUS, 32'hffff_ffff);
		foreach (ra[k]) begin
			bus(0, ra[k], 0);
			chk(rd, rv[k]);
		end
		// channel, path and all-ones entries, unpoliced; fill, then stall
		e = '{32'h2006_4005, 32'h0001_0051, 32'h000c_8007, 3, 2, 6, 6};
		ent(0, e);
		e[0:2] = '{32'h3000_0005, 32'h0002_0050, 32'h0000_0009};
		ent(1, e);
		e[0:2] = '{32'h2fff_ffff, 32'h0003_0052, 32'h0123_4456};
		ent(2, e);
		rmode = 0;
		for (int k = 0; k < 30; k++) begin
			send(k % 4 == 3 ? 12'h006 : k % 4 == 2 ? 12'hfff : 12'h005,
				k % 4 == 0 ? 16'd100 : k % 4 == 2 ? 16'hffff : 16'd77);
		end
		repeat (40) @(posedge clock_i);
		chk(cell_ready_o, 0);
		rmode = 2;
		slow = 1'b1;
		drain();
		rmode = 1;
		slow = 1'b0;
		// setup inside the reserved path range is refused
		bus(1, `ACP_REG_SVC_VPI, 32'h002f_0020);
		vlo = 32;
		vhi = 47;
		e[0] = 32'h2000_0025;
		ent(3, e);
		send(12'h025, 16'h0001);
		drain();
		bus(1, `ACP_REG_SVC_VPI, 32'h0000_0fff);
		vlo = 4095;
		vhi = 0;
		// every type, setting and clp option against bursts
		for (int t = 0; t < 6; t++) begin
			for (int s = 1; s < 6; s++) begin
				for (int o = 0; o < 2; o++) begin
					e = '{32'h2000_1040, 32'(o << 8 | s << 4 | t) | 32'h0004_0000,
						32'h0000_2041, 3, 2, 6, 6};
					ent(4, e);
					repeat (8) @(posedge clock_i);
					repeat (10) send(12'h040, 16'h0001);
					drain();
				end
			end
		end
		bus(0, `ACP_REG_CNT_MISS, 0);
		chk(rd, n_miss);
		give_verdict();
	end
endmodule : tb
